// *** pkg/bmwf_pkg.sv ***
// Purpose: Shared constants and types for the bus monitor word formatter
// Assumes: 25 MHz core clock, words arrive already bit-decoded
// Notes: Output word bit 1 is vector bit 23 and is sent first
//
// Functional notes
// [R1] Every formatted output word is 24 bits: identity, content label, info.
// [R2] Sync pattern and parity bit are stripped; only 16 payload bits kept.
// [R3] Every bus, time or auxiliary word carries a 4-bit content label.
// [R4] Bus bit 4 lands in output bit 9; order kept through bit 24.
// [R5] Word errors use label 1100 on primary, 1000 on secondary, raw payload.
// [R6] Command 1111/1011, status 1110/1010, data 1101/1001 by channel.
// [R7] Time labels: high 0111, low 0110, microsecond 0101, response 0100.
// [R8] Labels 0011, 0010 reserved for user; low fill label marks empty slots.
// [R9] With tagging on, first command word is followed by high, low, usec time.
// [R10] Response time word counts bus response time in whole microseconds.
// [R11] Response time word sits directly ahead of its status word.
// [R12] Word errors are sync, Manchester, parity, gap, bit count; not protocol.
// [R13] The monitor only listens; nothing is ever driven onto the bus.
// [R14] Both channels accepted; each word keeps track of its channel.
// [R15] Bits 1-4 bus identity (zero is bus one), bits 5-8 label, bit 1 first.
// [R16] Incoming words are buffered so bursts survive waiting for slots.
package bmwf_pkg;

	localparam int OUT_W = 24;
	localparam int INFO_W = 16;
	localparam int LBL_W = 4;
	localparam int ID_MSB = 23;
	localparam int LBL_MSB = 19;
	localparam int FIFO_DEPTH = 4;

	// Content labels, both channels and auxiliary words
	localparam logic [3:0] LBL_CMD_A = 4'hf;
	localparam logic [3:0] LBL_STAT_A = 4'he;
	localparam logic [3:0] LBL_DATA_A = 4'hd;
	localparam logic [3:0] LBL_ERR_A = 4'hc;
	localparam logic [3:0] LBL_CMD_B = 4'hb;
	localparam logic [3:0] LBL_STAT_B = 4'ha;
	localparam logic [3:0] LBL_DATA_B = 4'h9;
	localparam logic [3:0] LBL_ERR_B = 4'h8;
	localparam logic [3:0] LBL_TIME_HI = 4'h7;
	localparam logic [3:0] LBL_TIME_LO = 4'h6;
	localparam logic [3:0] LBL_TIME_US = 4'h5;
	localparam logic [3:0] LBL_TIME_RSP = 4'h4;
	localparam logic [3:0] LBL_USER_1 = 4'h3;
	localparam logic [3:0] LBL_USER_2 = 4'h2;
	localparam logic [3:0] LBL_FILL = 4'h1;
	localparam logic [15:0] FILL_INFO = 16'h0000;

	// Microsecond prescaler
	localparam int CLK_PERIOD_NS = 40;
	localparam int USEC_NS = 1000;
	localparam int CYC_PER_US = (USEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] PRESC_LAST = 5'(CYC_PER_US - 1);
	localparam logic [15:0] RSP_MAX = 16'hffff;

	typedef enum logic [1:0] {
		WT_CMD = 2'b00,
		WT_STAT = 2'b01,
		WT_DATA = 2'b10
	} bmwf_wtype_e;

	// Decoded bus word: raw[19:17] sync, raw[16:1] payload, raw[0] parity
	typedef struct packed {
		logic chanB;
		bmwf_wtype_e wtype;
		logic [19:0] raw;
		logic syncErr;
		logic manchErr;
		logic gapErr;
		logic bitCntErr;
		logic protoErr;
	} bmwf_busword_s;

	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
		logic [15:0] us;
	} bmwf_time_s;

	typedef struct packed {
		logic [3:0] label;
		logic [15:0] info;
		logic tag;
		logic rsp;
		logic [15:0] rspUs;
		bmwf_time_s stamp;
	} bmwf_entry_s;

	localparam int ENTRY_W = $bits(bmwf_entry_s);

endpackage

// *** rtl/bmwf_fifo.sv ***
// Purpose: Small valid/ready FIFO in front of the output sequencer
// Assumes: Single clock, asynchronous active-low reset
// Notes: Ready is registered so the filling side sees a clean level
`timescale 1ns/1ns
`default_nettype none
module bmwf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [AW:0] count_q, count_d;
	logic rdy_q, rdy_d;
	logic push, pop;

	function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
		nextPtr = (p == LAST_IDX) ? '0 : p + 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////
	always_comb begin
		push = inValid && rdy_q;
		pop = outValid && outReady;
		wrPtr_d = push ? nextPtr(wrPtr_q) : wrPtr_q;
		rdPtr_d = pop ? nextPtr(rdPtr_q) : rdPtr_q;
		count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
		rdy_d = (count_d != FULL_CNT);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
			rdy_q <= 1'b0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
			rdy_q <= rdy_d;
		end
	end

	// Storage has no reset; contents only read when count says so
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	assign inReady = rdy_q;
	assign outValid = (count_q != '0);
	assign outData = mem[rdPtr_q];

endmodule
`default_nettype wire

// *** rtl/bmwf_formatter.sv ***
// Purpose: Turn monitored dual-channel bus words into labelled 24-bit words
// Assumes: Decoder hands one word per strobe with channel and error flags
// Notes: One formatted word per slot request; fill word when nothing waits
`timescale 1ns/1ns
`default_nettype none
module bmwf_formatter import bmwf_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Static configuration
	input wire logic [3:0] busId,
	input wire logic tagEnable,
	input wire logic rspEnable,
	// Time source
	input wire bmwf_time_s timeNow,
	// Monitored words from the receive-only decoder
	input wire logic wordValid,
	input wire bmwf_busword_s word,
	output logic wordReady,
	// Output slots
	input wire logic slotReq,
	output logic outValid,
	output logic [23:0] outWord
);

	typedef enum logic [2:0] {
		S_PICK = 3'b000,
		S_BODY = 3'b001,
		S_THI = 3'b010,
		S_TLO = 3'b011,
		S_TUS = 3'b100
	} bmwf_seq_e;

	////////////////////////////////////////////////////////////////////
	// Label decode, used on the input side only
	function automatic logic [3:0] wordLabel(input logic chanB,
		input bmwf_wtype_e t, input logic err);
		logic [3:0] l;
		l = LBL_DATA_A;
		if (err) begin
			l = chanB ? LBL_ERR_B : LBL_ERR_A;
		end else begin
			unique case (t)
				WT_CMD: l = chanB ? LBL_CMD_B : LBL_CMD_A;
				WT_STAT: l = chanB ? LBL_STAT_B : LBL_STAT_A;
				default: l = chanB ? LBL_DATA_B : LBL_DATA_A;
			endcase
		end
		return l;
	endfunction

	function automatic logic [23:0] pack(input logic [3:0] id,
		input logic [3:0] l, input logic [15:0] info);
		return {id, l, info};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Input side: labelling, time capture, response measurement
	logic [4:0] presc_q, presc_d;
	logic [15:0] gapUs_q, gapUs_d;
	logic prevCmd_q, prevCmd_d;
	logic accept, wordErr, parityErr, fifoReady;
	bmwf_entry_s inEntry, headEntry;
	logic headValid, headPop;

	always_comb begin
		accept = wordValid && fifoReady;
		// [R12] Word errors only
		// Odd parity over payload and parity bit; protocol errors ignored
		parityErr = ~^word.raw[16:0];
		wordErr = word.syncErr || word.manchErr || parityErr ||
			word.gapErr || word.bitCntErr;
		// [R3] Label every word
		// [R5] Error labels [R6] and [R14] channel-specific labels
		inEntry.label = wordLabel(word.chanB, word.wtype, wordErr);
		// [R2] Strip sync and parity
		// [R4] Bus bit 4 first into bit 9
		inEntry.info = word.raw[16:1];
		// [R9] Tag only the first command of a message
		// A command right after a command is the second of an RT-RT pair
		inEntry.tag = tagEnable && !wordErr && word.wtype == WT_CMD &&
			!prevCmd_q;
		inEntry.rsp = rspEnable && !wordErr && word.wtype == WT_STAT;
		inEntry.rspUs = gapUs_q;
		inEntry.stamp = timeNow;
		// [R10] Microsecond response count
		// Gap from previous word strobe, saturating rather than wrapping
		presc_d = (presc_q == PRESC_LAST) ? '0 : presc_q + 5'h01;
		gapUs_d = gapUs_q;
		if (presc_q == PRESC_LAST && gapUs_q != RSP_MAX) begin
			gapUs_d = gapUs_q + 16'h0001;
		end
		prevCmd_d = prevCmd_q;
		if (accept) begin
			gapUs_d = 16'h0000;
			presc_d = '0;
			prevCmd_d = (word.wtype == WT_CMD) && !wordErr;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_q <= '0;
			gapUs_q <= '0;
			prevCmd_q <= 1'b0;
		end else begin
			presc_q <= presc_d;
			gapUs_q <= gapUs_d;
			prevCmd_q <= prevCmd_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// [R16] Burst buffer
	// Full buffer drops ready; the decoder must hold its word meanwhile
	logic [ENTRY_W-1:0] headRaw;

	bmwf_fifo #(
		.WIDTH(ENTRY_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.inValid(wordValid),
		.inReady(fifoReady),
		.inData(inEntry),
		.outValid(headValid),
		.outReady(headPop),
		.outData(headRaw)
	);

	assign headEntry = bmwf_entry_s'(headRaw);
	assign wordReady = fifoReady;

	////////////////////////////////////////////////////////////////////
	// Output sequencer
	bmwf_seq_e state_q, state_d;
	bmwf_entry_s cur_q, cur_d;
	logic outValid_q, outValid_d;
	logic [23:0] outWord_q, outWord_d;

	always_comb begin
		state_d = state_q;
		cur_d = cur_q;
		headPop = 1'b0;
		outValid_d = slotReq;
		outWord_d = outWord_q;
		if (slotReq) begin
			// [R1] 24-bit words [R15] identity then label
			unique case (state_q)
				S_PICK: begin
					if (headValid) begin
						headPop = 1'b1;
						cur_d = headEntry;
						// [R11] Response word just ahead of status
						if (headEntry.rsp) begin
							outWord_d = pack(busId, LBL_TIME_RSP,
								headEntry.rspUs);
							state_d = S_BODY;
						end else begin
							outWord_d = pack(busId, headEntry.label,
								headEntry.info);
							state_d = headEntry.tag ? S_THI : S_PICK;
						end
					end else begin
						// [R8] Fill word
						outWord_d = pack(busId, LBL_FILL, FILL_INFO);
					end
				end
				S_BODY: begin
					outWord_d = pack(busId, cur_q.label, cur_q.info);
					state_d = cur_q.tag ? S_THI : S_PICK;
				end
				// [R7] Time labels [R9] high, low, micro order
				S_THI: begin
					outWord_d = pack(busId, LBL_TIME_HI, cur_q.stamp.hi);
					state_d = S_TLO;
				end
				S_TLO: begin
					outWord_d = pack(busId, LBL_TIME_LO, cur_q.stamp.lo);
					state_d = S_TUS;
				end
				S_TUS: begin
					outWord_d = pack(busId, LBL_TIME_US, cur_q.stamp.us);
					state_d = S_PICK;
				end
				default: begin
					outWord_d = pack(busId, LBL_FILL, FILL_INFO);
					state_d = S_PICK;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_PICK;
			cur_q <= '0;
			outValid_q <= 1'b0;
			outWord_q <= '0;
		end else begin
			state_q <= state_d;
			cur_q <= cur_d;
			outValid_q <= outValid_d;
			outWord_q <= outWord_d;
		end
	end

	assign outValid = outValid_q;
	assign outWord = outWord_q;
	// [R13] Receive only
	// No transmit path exists; the block has no bus driver at all

	////////////////////////////////////////////////////////////////////
	// Checks
	// [R15] Identity in answer
	chk_slot_answer: assert property ( // [R15]
		@(posedge core_clk) disable iff (!rst_n)
		slotReq |=> outValid && outWord[ID_MSB -: 4] == $past(busId))
		else $error("slot request not answered with bus identity");
	// [R1] Words only on request
	chk_no_spurious: assert property ( // [R1]
		@(posedge core_clk) disable iff (!rst_n)
		!slotReq |=> !outValid)
		else $error("word emitted without a slot request");
	// [R4] Payload into bits 9-24
	chk_info_order: assert property ( // [R4]
		@(posedge core_clk) disable iff (!rst_n)
		slotReq && state_q == S_PICK && headValid && !headEntry.rsp |=>
		outWord[INFO_W-1:0] == $past(headEntry.info))
		else $error("payload bits not kept in order");
	// [R5] Error label by channel
	chk_error_label: assert property ( // [R5]
		@(posedge core_clk) disable iff (!rst_n)
		accept && word.syncErr |->
		inEntry.label == (word.chanB ? 4'h8 : 4'hc))
		else $error("errored word has wrong label");
	// [R12] Protocol errors pass through
	chk_protocol_ok: assert property ( // [R12]
		@(posedge core_clk) disable iff (!rst_n)
		accept && word.protoErr && !wordErr |->
		inEntry.label != LBL_ERR_A && inEntry.label != LBL_ERR_B)
		else $error("protocol error treated as word error");
	// [R9] Micro time after low
	chk_time_seq: assert property ( // [R9]
		@(posedge core_clk) disable iff (!rst_n)
		slotReq && state_q == S_TUS |=> state_q == S_PICK &&
		outWord[LBL_MSB -: 4] == LBL_TIME_US &&
		$past(outWord[LBL_MSB -: 4]) == LBL_TIME_LO)
		else $error("time words out of order");
	// [R11] Status right after response
	chk_rsp_before: assert property ( // [R11]
		@(posedge core_clk) disable iff (!rst_n)
		slotReq && state_q == S_BODY |=>
		(outWord[LBL_MSB -: 4] == 4'he || outWord[LBL_MSB -: 4] == 4'ha) &&
		$past(outWord[LBL_MSB -: 4]) == LBL_TIME_RSP)
		else $error("response word not followed by its status");
	// [R10] Microsecond step
	chk_usec_rate: assert property ( // [R10]
		@(posedge core_clk) disable iff (!rst_n)
		!accept && presc_q == PRESC_LAST && gapUs_q == 16'h0001 |=>
		gapUs_q == 16'h0002 && presc_q == 5'h00)
		else $error("microsecond count not advanced");
	// [R8] Fill when empty
	chk_fill_word: assert property ( // [R8]
		@(posedge core_clk) disable iff (!rst_n)
		slotReq && state_q == S_PICK && !headValid |=>
		outWord[LBL_MSB -: 4] == LBL_FILL)
		else $error("empty slot not filled");
	// [R16] Accepted word buffered
	chk_push_seen: assert property ( // [R16]
		@(posedge core_clk) disable iff (!rst_n)
		accept |=> headValid)
		else $error("accepted word missing from buffer");
	// [R9] Second command untagged
	chk_tag_first: assert property ( // [R9]
		@(posedge core_clk) disable iff (!rst_n)
		accept && prevCmd_q |-> !inEntry.tag)
		else $error("command after command was tagged");
	// [R5] Errored words plain
	chk_err_no_tag: assert property ( // [R5]
		@(posedge core_clk) disable iff (!rst_n)
		accept && wordErr |-> !inEntry.tag && !inEntry.rsp)
		else $error("errored word given extra words");
	// [R11] Response word leads
	chk_rsp_lead: assert property ( // [R11]
		@(posedge core_clk) disable iff (!rst_n)
		slotReq && state_q == S_PICK && headValid && headEntry.rsp |=>
		state_q == S_BODY && outWord[LBL_MSB -: 4] == LBL_TIME_RSP)
		else $error("status not preceded by response word");
	// [R10] Response value carried
	chk_rsp_value: assert property ( // [R10]
		@(posedge core_clk) disable iff (!rst_n)
		slotReq && state_q == S_PICK && headValid && headEntry.rsp |=>
		outWord[INFO_W-1:0] == $past(headEntry.rspUs))
		else $error("response time not carried");
	// [R14] Channel in label
	chk_chan_label: assert property ( // [R14]
		@(posedge core_clk) disable iff (!rst_n)
		accept |-> inEntry.label[3] && inEntry.label[2] == !word.chanB)
		else $error("bus word label lost its channel");
	// [R10] Gap restarts per word
	chk_gap_clear: assert property ( // [R10]
		@(posedge core_clk) disable iff (!rst_n)
		accept |=> gapUs_q == 16'h0000 && presc_q == 5'h00)
		else $error("response gap not restarted");
	// [R9] Tagged command then time
	chk_tag_start: assert property ( // [R9]
		@(posedge core_clk) disable iff (!rst_n)
		slotReq && state_q == S_PICK && headValid && !headEntry.rsp &&
		headEntry.tag |=> state_q == S_THI &&
		(outWord[LBL_MSB -: 4] == LBL_CMD_A ||
		outWord[LBL_MSB -: 4] == LBL_CMD_B))
		else $error("tagged command not followed by time words");

endmodule
`default_nettype wire

// *** test/bmwf_decoder_model.sv ***
// Purpose: Receive-only bus decoder stand-in that offers monitored words
// Assumes: Bench queues words in bus arrival order
// Notes: Offer held until taken; idle word toggles so stale data never matches
`timescale 1ns/1ns
`default_nettype none
module bmwf_decoder_model import bmwf_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Word handshake
	output logic wordValid,
	output bmwf_busword_s word,
	input wire logic wordReady
);
	bmwf_busword_s pend[$];

	////////////////////////////////////////////////////////////////////////
	// Channel kept per word
	always @(posedge core_clk) begin
		if (!rst_n) begin
			wordValid <= 1'b0;
			word <= '0;
		end else if (!wordValid || wordReady) begin
			if (pend.size() > 0) begin
				wordValid <= 1'b1;
				word <= pend.pop_front();
			end else begin
				wordValid <= 1'b0;
				word <= ~word;
			end
		end
	end
endmodule
`default_nettype wire

// *** test/bmwf_formatter_tb.sv ***
// Purpose: Self-checking bench for the bus monitor word formatter
// Assumes: 25 MHz clock, decoder model on the word side
// Notes: Response gap chosen mid-microsecond so rounding cannot flip it
`timescale 1ns/1ns
`default_nettype none
module bmwf_formatter_tb;
	import bmwf_pkg::*;
	logic core_clk, rst_n, tagEnable, rspEnable;
	logic wordValid, wordReady, slotReq, outValid;
	logic [3:0] busId;
	logic [23:0] outWord;
	bmwf_time_s timeNow;
	bmwf_busword_s word;
	int errors = 0;
	int checksDone = 0;

	bmwf_decoder_model dec (.core_clk(core_clk), .rst_n(rst_n),
		.wordValid(wordValid), .word(word), .wordReady(wordReady));
	bmwf_formatter dut (.core_clk(core_clk), .rst_n(rst_n), .busId(busId),
		.tagEnable(tagEnable), .rspEnable(rspEnable), .timeNow(timeNow),
		.wordValid(wordValid), .word(word), .wordReady(wordReady),
		.slotReq(slotReq), .outValid(outValid), .outWord(outWord));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (errors == 0 && checksDone > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic bmwf_busword_s mk(input logic chB,
			input bmwf_wtype_e t, input logic [15:0] p, input logic [4:0] e);
		bmwf_busword_s w;
		w = '0;
		w.chanB = chB;
		w.wtype = t;
		// Odd parity over payload; e[4] spoils it
		w.raw = {3'b100, p, (~^p) ^ e[4]};
		{w.syncErr, w.manchErr, w.gapErr, w.bitCntErr} = e[3:0];
		return w;
	endfunction

	task automatic push(input bmwf_busword_s w);
		dec.pend.push_back(w);
	endtask

	task automatic settle();
		for (int n = 0; n < 40; n++) begin
			@(posedge core_clk);
			#1;
			if (wordValid !== 1'b1 && dec.pend.size() == 0)
				return;
		end
		errors++;
	endtask

	task automatic slot(input logic [3:0] lbl, input logic [15:0] info);
		@(posedge core_clk);
		slotReq <= 1'b1;
		@(posedge core_clk);
		slotReq <= 1'b0;
		#1;
		check({23'h0, outValid}, 24'h1);
		check(outWord, {busId, lbl, info});
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic testLabels();
		logic [3:0] lbl [6] = '{LBL_CMD_A, LBL_STAT_A, LBL_DATA_A,
			LBL_CMD_B, LBL_STAT_B, LBL_DATA_B};
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk);
			busId <= 4'(i + 9);
			#1;
			push(mk(i > 2, bmwf_wtype_e'(i % 3), 16'ha5c3 + 16'(i), 5'h0));
			settle();
			slot(lbl[i], 16'ha5c3 + 16'(i));
		end
	endtask

	task automatic testErrors();
		bmwf_busword_s w;
		for (int i = 0; i < 6; i++) begin
			w = mk(i[0], WT_DATA, 16'h0f31 + 16'(i),
				i < 5 ? 5'h1 << (4 - i) : 5'h0);
			w.protoErr = (i == 5);
			push(w);
		end
		repeat (10) @(posedge core_clk);
		#1;
		check({23'h0, wordReady}, 24'h0);
		for (int i = 0; i < 5; i++)
			slot(i[0] ? LBL_ERR_B : LBL_ERR_A, 16'h0f31 + 16'(i));
		slot(LBL_DATA_B, 16'h0f36);
		slot(LBL_FILL, FILL_INFO);
	endtask

	task automatic testTags();
		@(posedge core_clk);
		tagEnable <= 1'b1;
		#1;
		push(mk(1'b0, WT_DATA, 16'h1357, 5'h0));
		push(mk(1'b0, WT_CMD, 16'h2468, 5'h0));
		push(mk(1'b0, WT_CMD, 16'h1111, 5'h0));
		settle();
		// Time moves on after capture; tags must keep the captured value
		@(posedge core_clk);
		timeNow <= '{hi: 16'h2b3c, lo: 16'h4d5e, us: 16'h6f70};
		slot(LBL_DATA_A, 16'h1357);
		slot(LBL_CMD_A, 16'h2468);
		slot(LBL_TIME_HI, 16'h1a2b);
		slot(LBL_TIME_LO, 16'h3c4d);
		slot(LBL_TIME_US, 16'h5e6f);
		slot(LBL_CMD_A, 16'h1111);
	endtask

	task automatic testRsp();
		@(posedge core_clk);
		tagEnable <= 1'b0;
		rspEnable <= 1'b1;
		#1;
		push(mk(1'b1, WT_DATA, 16'h7e01, 5'h0));
		settle();
		// About 62 cycles apart: two whole microseconds
		repeat (60) @(posedge core_clk);
		#1;
		push(mk(1'b1, WT_STAT, 16'h0c80, 5'h0));
		push(mk(1'b0, WT_STAT, 16'h0c81, 5'h10));
		settle();
		slot(LBL_DATA_B, 16'h7e01);
		slot(LBL_TIME_RSP, 16'h0002);
		slot(LBL_STAT_B, 16'h0c80);
		slot(LBL_ERR_A, 16'h0c81);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		repeat (5000) @(posedge core_clk);
		errors++;
		final_report();
	end

	initial begin
		rst_n = 1'b0;
		busId = 4'h0;
		tagEnable = 1'b0;
		rspEnable = 1'b0;
		slotReq = 1'b0;
		timeNow = '{hi: 16'h1a2b, lo: 16'h3c4d, us: 16'h5e6f};
		repeat (2) @(posedge core_clk);
		#1;
		check({23'h0, outValid}, 24'h0);
		check(outWord, 24'h0);
		@(posedge core_clk);
		rst_n <= 1'b1;
		testLabels();
		testErrors();
		testTags();
		testRsp();
		final_report();
	end
endmodule
`default_nettype wire
